/* adc_ctrl_pkg.sv */
// Register indices (byte address is four times the index), field positions and codes
package adc_ctrl_pkg;
   localparam logic [11:0] OFS_GAIN_VALUE = 12'h044;
   localparam logic [11:0] OFS_FORMAT_SEL = 12'h043;
   localparam logic [11:0] OFS_FILTER_KIND = 12'h041;
   localparam logic [11:0] OFS_ZONE_FIELD = 12'h042;
   localparam logic [11:0] OFS_OUTPUT_FORMAT_CONTROL = 12'h04b;
   localparam logic [11:0] OFS_DECIMATION_CONTROL = 12'h04d;
   localparam logic [11:0] OFS_ZONE_SELECT_CONTROL = 12'h04e;
   localparam logic [11:0] OFS_GAIN_AND_REORDER_ENABLE = 12'h052;
   localparam logic [11:0] OFS_REORDER_ENABLE_SECOND = 12'h072;
   localparam logic [11:0] OFS_LSB_REPLACE_ENABLE = 12'h0ab;
   localparam logic [11:0] OFS_LSB_REPLACE_SELECT = 12'h0ad;
   localparam logic [11:0] OFS_PAGE_RESET = 12'h100;
   localparam logic [11:0] OFS_LANE_REORDER_MAP = 12'h104;
   localparam logic [11:0] OFS_SETTINGS_STATUS = 12'h108;
   localparam int BIT_FORMAT_EN = 5;
   localparam int BIT_DEC_EN = 3;
   localparam int BIT_ZONE_EN = 7;
   localparam int BIT_REORDER_A = 7;
   localparam int BIT_GAIN_EN = 0;
   localparam int BIT_REORDER_B = 3;
   localparam int BIT_LSB_EN = 0;
   localparam int BIT_FILTER_TOP = 4;
   localparam logic [7:0] RESET_ZERO = 8'h00;
   localparam logic [7:0] RESET_FILTER_KIND = 8'h02;
   localparam logic [3:0] FILTER_LOWPASS = 4'ha;
   localparam logic [3:0] FILTER_HIGHPASS = 4'he;
   localparam logic [1:0] LSB_SEL_DATA = 2'h0;
   localparam logic [1:0] LSB_SEL_OVR = 2'h3;
   localparam int GAIN_SHIFT = 5;
   typedef enum logic [1:0] {PR_IDLE, PR_HIGH} pulse_state_t;
endpackage : adc_ctrl_pkg

/* sample_path.sv */
// Per-channel sample path: gain, format and fast over-range LSB substitution
`timescale 1ns/1ps
module sample_path #(
   parameter int WIDTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] sample_in,
   input wire logic ovr_in,
   input wire logic gain_on,
   input wire logic [6:0] gain_code,
   input wire logic offset_binary,
   input wire logic lsb_ovr,
   output logic [WIDTH-1:0] sample_out
);
   logic [WIDTH-1:0] out_reg;
   logic [WIDTH-1:0] out_next;
   logic signed [WIDTH+7:0] product;
   logic signed [WIDTH+7:0] scaled;
   logic signed [WIDTH-1:0] gained;
   localparam logic signed [WIDTH+7:0] MAXV = (WIDTH+8)'(2**(WIDTH-1) - 1);
   localparam logic signed [WIDTH+7:0] MINV = -(WIDTH+8)'(2**(WIDTH-1));

   always_comb begin
      product = $signed(sample_in) * $signed({1'b0, gain_code});
      scaled = product >>> adc_ctrl_pkg::GAIN_SHIFT;
      // Saturate instead of wrapping: a wrap would flip the sign at full scale
      if (scaled > MAXV) begin
         gained = MAXV[WIDTH-1:0];
      end else if (scaled < MINV) begin
         gained = MINV[WIDTH-1:0];
      end else begin
         gained = scaled[WIDTH-1:0];
      end
      out_next = gain_on ? gained : sample_in;
      if (offset_binary) begin
         out_next[WIDTH-1] = ~out_next[WIDTH-1];
      end
      if (lsb_ovr) begin
         out_next[0] = ovr_in;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         out_reg <= '0;
      end else begin
         out_reg <= out_next;
      end
   end

   assign sample_out = out_reg;
endmodule : sample_path

/* adc_output_digital_control.sv */
// Output digital control registers with APB access and two sample channels
//
// Functional notes
// - Format enable clear gives two's complement
// - Decimation enable gates filter kind field
// - Zone enable gates three-bit zone field
// - Reorder only when both enable bits set
// - Gain enable gates digital gain value
// - LSB enable allows over-range LSB substitution
// - Code 00 data, 11 over-range LSB
// - Decimation enable resets to zero
// - Settings apply after 0-1-0 reset pulse
// - Format select one gives offset binary when format enable is set
// - Filter codes 1010 lowpass, 1110 highpass
// - Gain scales samples by code over 32
`timescale 1ns/1ps
module adc_output_digital_control #(
   parameter int WIDTH = 16,
   parameter int LANES = 4
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [WIDTH-1:0] CH_A_SAMPLE,
   input wire logic [WIDTH-1:0] CH_B_SAMPLE,
   input wire logic CH_A_FAST_OVERRANGE_FLAG,
   input wire logic CH_B_FAST_OVERRANGE_FLAG,
   output logic [WIDTH-1:0] CH_A_DATA,
   output logic [WIDTH-1:0] CH_B_DATA,
   output logic [3:0] DECIMATOR_FILTER_KIND,
   output logic FILTER_HIGHPASS,
   output logic FILTER_INVALID,
   output logic [2:0] ZONE_SELECT,
   output logic ZONE_SELECT_VALID,
   output logic REORDER_ACTIVE,
   output logic [2*LANES-1:0] LANE_REORDER_MAP
);
   // Shadow registers: software view
   logic [7:0] gain_reg, gain_next;
   logic format_sel_reg, format_sel_next;
   logic [3:0] filter_reg, filter_next;
   logic [2:0] zone_reg, zone_next;
   logic format_en_reg, format_en_next;
   logic dec_en_reg, dec_en_next;
   logic zone_en_reg, zone_en_next;
   logic gain_apply_enable_reg, gain_apply_enable_next;
   logic reorder_a_reg, reorder_a_next;
   logic reorder_b_reg, reorder_b_next;
   logic lsb_en_reg, lsb_en_next;
   logic [1:0] lsb_sel_reg, lsb_sel_next;
   logic [2*LANES-1:0] map_reg, map_next;
   logic pulse_bit_reg, pulse_bit_next;
   // Active copies: what the data path uses
   logic [6:0] act_gain_reg, act_gain_next;
   logic act_format_reg, act_format_next;
   logic act_dec_en_reg, act_dec_en_next;
   logic [3:0] act_filter_reg, act_filter_next;
   logic act_zone_en_reg, act_zone_en_next;
   logic [2:0] act_zone_reg, act_zone_next;
   logic act_gain_on_reg, act_gain_on_next;
   logic act_reorder_reg, act_reorder_next;
   logic act_lsb_en_reg, act_lsb_en_next;
   logic [1:0] act_lsb_sel_reg, act_lsb_sel_next;
   logic [2*LANES-1:0] act_map_reg, act_map_next;
   logic pending_reg, pending_next;
   adc_ctrl_pkg::pulse_state_t pstate_reg, pstate_next;
   logic [31:0] rdata_reg, rdata_next;
   logic wr, rd, apply;
   logic [7:0] wb;
   logic decoded;
   logic [11:0] idx;
   logic [3:0] kind;
   logic lsb_ovr;

   assign wr = PSEL & PENABLE & PWRITE;
   assign rd = PSEL & ~PENABLE & ~PWRITE;
   assign wb = PWDATA[7:0];
   // One register per word; a misaligned address falls on an unused index
   assign idx = (PADDR[1:0] == 2'b00) ? {2'b00, PADDR[11:2]} : 12'hfff;

   always_comb begin
      unique case (idx)
         adc_ctrl_pkg::OFS_GAIN_VALUE, adc_ctrl_pkg::OFS_FORMAT_SEL, adc_ctrl_pkg::OFS_FILTER_KIND,
         adc_ctrl_pkg::OFS_ZONE_FIELD, adc_ctrl_pkg::OFS_OUTPUT_FORMAT_CONTROL,
         adc_ctrl_pkg::OFS_DECIMATION_CONTROL, adc_ctrl_pkg::OFS_ZONE_SELECT_CONTROL,
         adc_ctrl_pkg::OFS_GAIN_AND_REORDER_ENABLE, adc_ctrl_pkg::OFS_REORDER_ENABLE_SECOND,
         adc_ctrl_pkg::OFS_LSB_REPLACE_ENABLE, adc_ctrl_pkg::OFS_LSB_REPLACE_SELECT,
         adc_ctrl_pkg::OFS_PAGE_RESET, adc_ctrl_pkg::OFS_LANE_REORDER_MAP,
         adc_ctrl_pkg::OFS_SETTINGS_STATUS: decoded = 1'b1;
         default: decoded = 1'b0;
      endcase
   end

   // Register writes; reserved bits are dropped so they never steer logic
   always_comb begin
      gain_next = gain_reg;
      format_sel_next = format_sel_reg;
      filter_next = filter_reg;
      zone_next = zone_reg;
      format_en_next = format_en_reg;
      dec_en_next = dec_en_reg;
      zone_en_next = zone_en_reg;
      gain_apply_enable_next = gain_apply_enable_reg;
      reorder_a_next = reorder_a_reg;
      reorder_b_next = reorder_b_reg;
      lsb_en_next = lsb_en_reg;
      lsb_sel_next = lsb_sel_reg;
      map_next = map_reg;
      pulse_bit_next = pulse_bit_reg;
      if (wr) begin
         case (idx)
            adc_ctrl_pkg::OFS_GAIN_VALUE: gain_next = {1'b0, wb[6:0]};
            adc_ctrl_pkg::OFS_FORMAT_SEL: format_sel_next = wb[0];
            adc_ctrl_pkg::OFS_FILTER_KIND: filter_next = {wb[adc_ctrl_pkg::BIT_FILTER_TOP], wb[2:0]};
            adc_ctrl_pkg::OFS_ZONE_FIELD: zone_next = wb[2:0];
            adc_ctrl_pkg::OFS_OUTPUT_FORMAT_CONTROL: format_en_next = wb[adc_ctrl_pkg::BIT_FORMAT_EN];
            adc_ctrl_pkg::OFS_DECIMATION_CONTROL: dec_en_next = wb[adc_ctrl_pkg::BIT_DEC_EN];
            adc_ctrl_pkg::OFS_ZONE_SELECT_CONTROL: zone_en_next = wb[adc_ctrl_pkg::BIT_ZONE_EN];
            adc_ctrl_pkg::OFS_GAIN_AND_REORDER_ENABLE: begin
               reorder_a_next = wb[adc_ctrl_pkg::BIT_REORDER_A];
               gain_apply_enable_next = wb[adc_ctrl_pkg::BIT_GAIN_EN];
            end
            adc_ctrl_pkg::OFS_REORDER_ENABLE_SECOND: reorder_b_next = wb[adc_ctrl_pkg::BIT_REORDER_B];
            adc_ctrl_pkg::OFS_LSB_REPLACE_ENABLE: lsb_en_next = wb[adc_ctrl_pkg::BIT_LSB_EN];
            adc_ctrl_pkg::OFS_LSB_REPLACE_SELECT: lsb_sel_next = wb[1:0];
            adc_ctrl_pkg::OFS_PAGE_RESET: pulse_bit_next = wb[0];
            adc_ctrl_pkg::OFS_LANE_REORDER_MAP: map_next = PWDATA[2*LANES-1:0];
            default: pulse_bit_next = pulse_bit_reg;
         endcase
      end
   end

   // Pulse detector: only a completed 0-1-0 sequence copies the settings
   always_comb begin
      pstate_next = pstate_reg;
      apply = 1'b0;
      case (pstate_reg)
         adc_ctrl_pkg::PR_IDLE: if (pulse_bit_reg) pstate_next = adc_ctrl_pkg::PR_HIGH;
         adc_ctrl_pkg::PR_HIGH: begin
            if (!pulse_bit_reg) begin
               pstate_next = adc_ctrl_pkg::PR_IDLE;
               apply = 1'b1;
            end
         end
         default: pstate_next = adc_ctrl_pkg::PR_IDLE;
      endcase
   end

   always_comb begin
      act_gain_next = act_gain_reg;
      act_format_next = act_format_reg;
      act_dec_en_next = act_dec_en_reg;
      act_filter_next = act_filter_reg;
      act_zone_en_next = act_zone_en_reg;
      act_zone_next = act_zone_reg;
      act_gain_on_next = act_gain_on_reg;
      act_reorder_next = act_reorder_reg;
      act_lsb_en_next = act_lsb_en_reg;
      act_lsb_sel_next = act_lsb_sel_reg;
      act_map_next = act_map_reg;
      // Any write to a setting marks the page dirty until the next pulse
      pending_next = pending_reg | (wr & decoded & (idx != adc_ctrl_pkg::OFS_PAGE_RESET));
      if (apply) begin
         act_gain_next = gain_reg[6:0];
         act_format_next = format_en_reg & format_sel_reg;
         act_dec_en_next = dec_en_reg;
         act_filter_next = filter_reg;
         act_zone_en_next = zone_en_reg;
         act_zone_next = zone_reg;
         act_gain_on_next = gain_apply_enable_reg;
         act_reorder_next = reorder_a_reg & reorder_b_reg;
         act_lsb_en_next = lsb_en_reg;
         act_lsb_sel_next = lsb_sel_reg;
         act_map_next = map_reg;
         pending_next = 1'b0;
      end
   end

   // Readback; write-only reorder bits and reserved bits read zero
   always_comb begin
      rdata_next = rdata_reg;
      if (rd) begin
         rdata_next = '0;
         case (idx)
            adc_ctrl_pkg::OFS_GAIN_VALUE: rdata_next[7:0] = gain_reg;
            adc_ctrl_pkg::OFS_FORMAT_SEL: rdata_next[0] = format_sel_reg;
            adc_ctrl_pkg::OFS_FILTER_KIND: rdata_next[7:0] = {3'h0, filter_reg[3], 1'b0, filter_reg[2:0]};
            adc_ctrl_pkg::OFS_ZONE_FIELD: rdata_next[2:0] = zone_reg;
            adc_ctrl_pkg::OFS_OUTPUT_FORMAT_CONTROL: rdata_next[adc_ctrl_pkg::BIT_FORMAT_EN] = format_en_reg;
            adc_ctrl_pkg::OFS_DECIMATION_CONTROL: rdata_next[adc_ctrl_pkg::BIT_DEC_EN] = dec_en_reg;
            adc_ctrl_pkg::OFS_ZONE_SELECT_CONTROL: rdata_next[adc_ctrl_pkg::BIT_ZONE_EN] = zone_en_reg;
            adc_ctrl_pkg::OFS_GAIN_AND_REORDER_ENABLE:
               rdata_next[adc_ctrl_pkg::BIT_GAIN_EN] = gain_apply_enable_reg;
            adc_ctrl_pkg::OFS_LSB_REPLACE_ENABLE: rdata_next[adc_ctrl_pkg::BIT_LSB_EN] = lsb_en_reg;
            adc_ctrl_pkg::OFS_LSB_REPLACE_SELECT: rdata_next[1:0] = lsb_sel_reg;
            adc_ctrl_pkg::OFS_PAGE_RESET: rdata_next[0] = pulse_bit_reg;
            adc_ctrl_pkg::OFS_LANE_REORDER_MAP: rdata_next[2*LANES-1:0] = map_reg;
            adc_ctrl_pkg::OFS_SETTINGS_STATUS: rdata_next[3:0] = {FILTER_INVALID, act_reorder_reg,
                                                                  pstate_reg == adc_ctrl_pkg::PR_HIGH, pending_reg};
            default: rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         gain_reg <= adc_ctrl_pkg::RESET_ZERO;
         format_sel_reg <= 1'b0;
         filter_reg <= adc_ctrl_pkg::RESET_FILTER_KIND[3:0];
         zone_reg <= 3'h0;
         format_en_reg <= 1'b0;
         dec_en_reg <= 1'b0;
         zone_en_reg <= 1'b0;
         gain_apply_enable_reg <= 1'b0;
         reorder_a_reg <= 1'b0;
         reorder_b_reg <= 1'b0;
         lsb_en_reg <= 1'b0;
         lsb_sel_reg <= 2'h0;
         map_reg <= '0;
         pulse_bit_reg <= 1'b0;
         act_gain_reg <= 7'h00;
         act_format_reg <= 1'b0;
         act_dec_en_reg <= 1'b0;
         act_filter_reg <= adc_ctrl_pkg::RESET_FILTER_KIND[3:0];
         act_zone_en_reg <= 1'b0;
         act_zone_reg <= 3'h0;
         act_gain_on_reg <= 1'b0;
         act_reorder_reg <= 1'b0;
         act_lsb_en_reg <= 1'b0;
         act_lsb_sel_reg <= 2'h0;
         act_map_reg <= '0;
         pending_reg <= 1'b0;
         pstate_reg <= adc_ctrl_pkg::PR_IDLE;
         rdata_reg <= 32'h0000_0000;
      end else begin
         gain_reg <= gain_next;
         format_sel_reg <= format_sel_next;
         filter_reg <= filter_next;
         zone_reg <= zone_next;
         format_en_reg <= format_en_next;
         dec_en_reg <= dec_en_next;
         zone_en_reg <= zone_en_next;
         gain_apply_enable_reg <= gain_apply_enable_next;
         reorder_a_reg <= reorder_a_next;
         reorder_b_reg <= reorder_b_next;
         lsb_en_reg <= lsb_en_next;
         lsb_sel_reg <= lsb_sel_next;
         map_reg <= map_next;
         pulse_bit_reg <= pulse_bit_next;
         act_gain_reg <= act_gain_next;
         act_format_reg <= act_format_next;
         act_dec_en_reg <= act_dec_en_next;
         act_filter_reg <= act_filter_next;
         act_zone_en_reg <= act_zone_en_next;
         act_zone_reg <= act_zone_next;
         act_gain_on_reg <= act_gain_on_next;
         act_reorder_reg <= act_reorder_next;
         act_lsb_en_reg <= act_lsb_en_next;
         act_lsb_sel_reg <= act_lsb_sel_next;
         act_map_reg <= act_map_next;
         pending_reg <= pending_next;
         pstate_reg <= pstate_next;
         rdata_reg <= rdata_next;
      end
   end

   // Filter control falls back to 2x low-pass whenever the mode field is not in charge
   assign kind = act_dec_en_reg ? act_filter_reg : adc_ctrl_pkg::FILTER_LOWPASS;
   assign DECIMATOR_FILTER_KIND = kind;
   assign FILTER_HIGHPASS = (kind == adc_ctrl_pkg::FILTER_HIGHPASS);
   assign FILTER_INVALID = (kind != adc_ctrl_pkg::FILTER_LOWPASS) && !FILTER_HIGHPASS;
   assign ZONE_SELECT_VALID = act_zone_en_reg;
   assign ZONE_SELECT = act_zone_en_reg ? act_zone_reg : 3'h0;
   assign REORDER_ACTIVE = act_reorder_reg;
   assign LANE_REORDER_MAP = act_reorder_reg ? act_map_reg : '0;
   // Codes 01 and 10 are left as plain data since they have no defined meaning
   assign lsb_ovr = act_lsb_en_reg && (act_lsb_sel_reg == adc_ctrl_pkg::LSB_SEL_OVR);

   assign PREADY = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~decoded;
   assign PRDATA = rdata_reg;

   sample_path #(.WIDTH(WIDTH)) path_a (
      .clk(SYS_CLK),
      .rst(RST),
      .sample_in(CH_A_SAMPLE),
      .ovr_in(CH_A_FAST_OVERRANGE_FLAG),
      .gain_on(act_gain_on_reg),
      .gain_code(act_gain_reg),
      .offset_binary(act_format_reg),
      .lsb_ovr(lsb_ovr),
      .sample_out(CH_A_DATA)
   );

   sample_path #(.WIDTH(WIDTH)) path_b (
      .clk(SYS_CLK),
      .rst(RST),
      .sample_in(CH_B_SAMPLE),
      .ovr_in(CH_B_FAST_OVERRANGE_FLAG),
      .gain_on(act_gain_on_reg),
      .gain_code(act_gain_reg),
      .offset_binary(act_format_reg),
      .lsb_ovr(lsb_ovr),
      .sample_out(CH_B_DATA)
   );
endmodule : adc_output_digital_control

/* adc_output_digital_control_assertions.sv */
// Concurrent checks on the ports of the output digital control page
`timescale 1ns/1ps
module adc_output_digital_control_assertions #(
   parameter int WIDTH = 16,
   parameter int LANES = 4
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [WIDTH-1:0] CH_A_DATA,
   input wire logic [WIDTH-1:0] CH_B_DATA,
   input wire logic [3:0] DECIMATOR_FILTER_KIND,
   input wire logic FILTER_HIGHPASS,
   input wire logic FILTER_INVALID,
   input wire logic [2:0] ZONE_SELECT,
   input wire logic ZONE_SELECT_VALID,
   input wire logic REORDER_ACTIVE,
   input wire logic [2*LANES-1:0] LANE_REORDER_MAP
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);
   logic page_wr;
   assign page_wr = PSEL && PENABLE && PWRITE && (PADDR == {adc_ctrl_pkg::OFS_PAGE_RESET[9:0], 2'b00});
   sequence s_access;
      PSEL && PENABLE;
   endsequence
   sequence s_read(logic [11:0] a);
      PSEL && PENABLE && !PWRITE && (PADDR == {a[9:0], 2'b00});
   endsequence
   property p_ready;
      s_access |-> PREADY;
   endproperty
   property p_err_phase;
      PSLVERR |-> PSEL && PENABLE;
   endproperty
   property p_err_data;
      s_access and (!PWRITE && PSLVERR) |-> PRDATA == 32'h0;
   endproperty
   property p_reorder_a_reads_zero;
      s_read(adc_ctrl_pkg::OFS_GAIN_AND_REORDER_ENABLE) |-> PRDATA[31:1] == 31'h0;
   endproperty
   property p_dec_reads;
      s_read(adc_ctrl_pkg::OFS_DECIMATION_CONTROL) |-> (PRDATA & ~32'h8) == 32'h0;
   endproperty
   property p_highpass;
      FILTER_HIGHPASS == (DECIMATOR_FILTER_KIND == adc_ctrl_pkg::FILTER_HIGHPASS);
   endproperty
   property p_invalid;
      FILTER_INVALID == (DECIMATOR_FILTER_KIND != 4'ha && DECIMATOR_FILTER_KIND != 4'he);
   endproperty
   property p_zone_gated;
      !ZONE_SELECT_VALID |-> ZONE_SELECT == 3'h0;
   endproperty
   property p_map_gated;
      !REORDER_ACTIVE |-> LANE_REORDER_MAP == '0;
   endproperty
   property p_apply_only;
      $changed(REORDER_ACTIVE) || $changed(DECIMATOR_FILTER_KIND) || $changed(ZONE_SELECT_VALID)
         |-> $past(page_wr, 1) || $past(page_wr, 2) || $past(page_wr, 3);
   endproperty
   a_ready: assert property (p_ready) else $error("access phase without ready");
   a_err_phase: assert property (p_err_phase) else $error("error flag outside access");
   a_err_data: assert property (p_err_data) else $error("unmapped read not zero");
   a_reorder_a_reads_zero: assert property (p_reorder_a_reads_zero) else $error("reorder bit read back");
   a_dec_reads: assert property (p_dec_reads) else $error("reserved decimation bits read");
   a_highpass: assert property (p_highpass) else $error("highpass flag wrong");
   a_invalid: assert property (p_invalid) else $error("invalid flag wrong");
   a_zone_gated: assert property (p_zone_gated) else $error("zone shown while disabled");
   a_map_gated: assert property (p_map_gated) else $error("map shown while inactive");
   a_apply_only: assert property (p_apply_only) else $error("setting changed without apply");
endmodule : adc_output_digital_control_assertions

bind adc_output_digital_control adc_output_digital_control_assertions #(.WIDTH(WIDTH), .LANES(LANES)) i_chk (
   .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CH_A_DATA(CH_A_DATA), .CH_B_DATA(CH_B_DATA),
   .DECIMATOR_FILTER_KIND(DECIMATOR_FILTER_KIND), .FILTER_HIGHPASS(FILTER_HIGHPASS), .FILTER_INVALID(FILTER_INVALID),
   .ZONE_SELECT(ZONE_SELECT), .ZONE_SELECT_VALID(ZONE_SELECT_VALID), .REORDER_ACTIVE(REORDER_ACTIVE),
   .LANE_REORDER_MAP(LANE_REORDER_MAP));

/* adc_output_digital_control_tb.sv */
// Directed testbench for the output digital control page
`timescale 1ns/1ps
module adc_output_digital_control_tb;
   logic SYS_CLK = 1'b0;
   logic RST = 1'b1;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0;
   logic [15:0] CH_A_SAMPLE = 16'h0000;
   logic [15:0] CH_B_SAMPLE = 16'h0000;
   logic CH_A_FAST_OVERRANGE_FLAG = 1'b0;
   logic CH_B_FAST_OVERRANGE_FLAG = 1'b0;
   logic [31:0] PRDATA;
   logic PREADY;
   logic PSLVERR;
   logic [15:0] CH_A_DATA;
   logic [15:0] CH_B_DATA;
   logic [3:0] DECIMATOR_FILTER_KIND;
   logic FILTER_HIGHPASS;
   logic FILTER_INVALID;
   logic [2:0] ZONE_SELECT;
   logic ZONE_SELECT_VALID;
   logic REORDER_ACTIVE;
   logic [7:0] LANE_REORDER_MAP;
   logic [31:0] rd;
   logic err;
   int n_mismatch = 0;
   int n_tests = 0;
   logic [11:0] cfg_addr [6] = '{adc_ctrl_pkg::OFS_OUTPUT_FORMAT_CONTROL, adc_ctrl_pkg::OFS_DECIMATION_CONTROL,
      adc_ctrl_pkg::OFS_ZONE_SELECT_CONTROL, adc_ctrl_pkg::OFS_GAIN_AND_REORDER_ENABLE,
      adc_ctrl_pkg::OFS_REORDER_ENABLE_SECOND, adc_ctrl_pkg::OFS_LSB_REPLACE_ENABLE};

   adc_output_digital_control #(.WIDTH(16), .LANES(4)) i_dut (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .CH_A_SAMPLE(CH_A_SAMPLE), .CH_B_SAMPLE(CH_B_SAMPLE),
      .CH_A_FAST_OVERRANGE_FLAG(CH_A_FAST_OVERRANGE_FLAG), .CH_B_FAST_OVERRANGE_FLAG(CH_B_FAST_OVERRANGE_FLAG),
      .CH_A_DATA(CH_A_DATA), .CH_B_DATA(CH_B_DATA), .DECIMATOR_FILTER_KIND(DECIMATOR_FILTER_KIND),
      .FILTER_HIGHPASS(FILTER_HIGHPASS), .FILTER_INVALID(FILTER_INVALID), .ZONE_SELECT(ZONE_SELECT),
      .ZONE_SELECT_VALID(ZONE_SELECT_VALID), .REORDER_ACTIVE(REORDER_ACTIVE), .LANE_REORDER_MAP(LANE_REORDER_MAP));

   initial begin
      forever #50 SYS_CLK = ~SYS_CLK;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Starts one edge late so a released strobe is never raised again in the same step
   // Takes the register index; the byte address is four times it
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
      @(posedge SYS_CLK);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= {addr[9:0], 2'b00};
      PWDATA <= data;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge SYS_CLK);
      end while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb

   task automatic apply;
      apb(1'b1, adc_ctrl_pkg::OFS_PAGE_RESET, 32'h1);
      apb(1'b1, adc_ctrl_pkg::OFS_PAGE_RESET, 32'h0);
      repeat (3) @(posedge SYS_CLK);
   endtask : apply

   task automatic cfg(input logic [7:0] v [6]);
      for (int i = 0; i < 6; i++) apb(1'b1, cfg_addr[i], {24'h0, v[i]});
   endtask : cfg

   task automatic out_chk(input logic [3:0] k, input logic [2:0] z, input logic zv, input logic ra, input logic [7:0] m);
      @(negedge SYS_CLK);
      chk("filter kind", 32'(DECIMATOR_FILTER_KIND), 32'(k));
      chk("highpass", 32'(FILTER_HIGHPASS), 32'(k == 4'he));
      chk("invalid", 32'(FILTER_INVALID), 32'(k != 4'ha && k != 4'he));
      chk("zone", 32'(ZONE_SELECT), 32'(z));
      chk("zone valid", 32'(ZONE_SELECT_VALID), 32'(zv));
      chk("reorder", 32'(REORDER_ACTIVE), 32'(ra));
      chk("map", 32'(LANE_REORDER_MAP), 32'(m));
   endtask : out_chk

   // Channel B always sees the opposite over-range level to channel A
   task automatic data_chk(input logic [15:0] a, input logic [15:0] b, input logic fa, input logic [15:0] ea,
                           input logic [15:0] eb);
      @(posedge SYS_CLK);
      CH_A_SAMPLE <= a;
      CH_B_SAMPLE <= b;
      CH_A_FAST_OVERRANGE_FLAG <= fa;
      CH_B_FAST_OVERRANGE_FLAG <= ~fa;
      repeat (2) @(posedge SYS_CLK);
      @(negedge SYS_CLK);
      chk("channel a", {16'h0, CH_A_DATA}, {16'h0, ea});
      chk("channel b", {16'h0, CH_B_DATA}, {16'h0, eb});
   endtask : data_chk

   task automatic t_reset;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, cfg_addr[i], 32'h0);
         chk("reset value", rd, 32'h0);
      end
      apb(1'b0, adc_ctrl_pkg::OFS_FILTER_KIND, 32'h0);
      chk("filter kind reset", rd, 32'h2);
      out_chk(4'ha, 3'h0, 1'b0, 1'b0, 8'h00);
   endtask : t_reset

   task automatic t_access;
      logic [7:0] wv [6] = '{8'h20, 8'h08, 8'h80, 8'h81, 8'h08, 8'h01};
      logic [7:0] ev [6] = '{8'h20, 8'h08, 8'h80, 8'h01, 8'h00, 8'h01};
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, cfg_addr[i], {24'h0, wv[i]});
         apb(1'b0, cfg_addr[i], 32'h0);
         chk("readback", rd, {24'h0, ev[i]});
      end
      apb(1'b1, 12'h0f0, 32'h5a);
      apb(1'b0, 12'h0f0, 32'h0);
      chk("unmapped data", rd, 32'h0);
      chk("unmapped error", 32'(err), 32'h1);
      out_chk(4'ha, 3'h0, 1'b0, 1'b0, 8'h00);
   endtask : t_access

   // Every field is set up first, then applied with every enable but the first reorder bit clear, then the enables follow
   task automatic t_gating;
      apb(1'b1, adc_ctrl_pkg::OFS_FORMAT_SEL, 32'h1);
      apb(1'b1, adc_ctrl_pkg::OFS_FILTER_KIND, 32'h16);
      apb(1'b1, adc_ctrl_pkg::OFS_ZONE_FIELD, 32'h2);
      apb(1'b1, adc_ctrl_pkg::OFS_GAIN_VALUE, 32'h40);
      apb(1'b1, adc_ctrl_pkg::OFS_LSB_REPLACE_SELECT, 32'h3);
      apb(1'b1, adc_ctrl_pkg::OFS_LANE_REORDER_MAP, 32'ha5);
      apb(1'b0, adc_ctrl_pkg::OFS_LANE_REORDER_MAP, 32'h0);
      chk("map readback", rd, 32'ha5);
      cfg('{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00});
      apply();
      out_chk(4'ha, 3'h0, 1'b0, 1'b0, 8'h00);
      data_chk(16'h0100, 16'hff00, 1'b1, 16'h0100, 16'hff00);
      cfg('{8'h20, 8'h08, 8'h80, 8'h81, 8'h08, 8'h01});
      out_chk(4'ha, 3'h0, 1'b0, 1'b0, 8'h00);
      apb(1'b0, adc_ctrl_pkg::OFS_SETTINGS_STATUS, 32'h0);
      chk("status pending", rd, 32'h1);
      apply();
      out_chk(4'he, 3'h2, 1'b1, 1'b1, 8'ha5);
      data_chk(16'h0100, 16'hff00, 1'b1, 16'h8201, 16'h7e00);
      data_chk(16'h0100, 16'hff00, 1'b0, 16'h8200, 16'h7e01);
   endtask : t_gating

   task automatic t_codes;
      logic [7:0] fk [3] = '{8'h12, 8'h10, 8'h16};
      logic [3:0] ek [3] = '{4'ha, 4'h8, 4'he};
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, adc_ctrl_pkg::OFS_FILTER_KIND, {24'h0, fk[i]});
         apply();
         out_chk(ek[i], 3'h2, 1'b1, 1'b1, 8'ha5);
      end
      apb(1'b1, adc_ctrl_pkg::OFS_LSB_REPLACE_SELECT, 32'h0);
      apb(1'b1, adc_ctrl_pkg::OFS_FORMAT_SEL, 32'h0);
      apply();
      data_chk(16'h0100, 16'hff00, 1'b1, 16'h0200, 16'hfe00);
   endtask : t_codes

   task automatic end_sim;
      if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim

   initial begin
      repeat (4) @(posedge SYS_CLK);
      RST <= 1'b0;
      t_reset();
      t_access();
      t_gating();
      t_codes();
      end_sim();
   end

   // Whole sequence needs well under a thousand cycles
   initial begin
      #2000000;
      n_mismatch++;
      end_sim();
   end
endmodule : adc_output_digital_control_tb
